// File: hdl/tpwm_consts.svh
/*
  register offsets, field positions, reset values and
  timing constants of the triggered pwm timer.
  assumes inclusion by bare name from the design files.
*/
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH

`define TPWM_ADDR_W        4
`define TPWM_DATA_W        16

`define TPWM_OFS_CTL0      4'h0
`define TPWM_OFS_CTL1      4'h1
`define TPWM_OFS_IOC0      4'h2
`define TPWM_OFS_IOC2      4'h3
`define TPWM_OFS_CNT       4'h4
`define TPWM_OFS_CCR0      4'h5
`define TPWM_OFS_CCR1      4'h6
`define TPWM_OFS_CCR2      4'h7
`define TPWM_OFS_CCR3      4'h8

`define TPWM_CTL0_CKS_LSB  0
`define TPWM_CTL0_CE_BIT   7
`define TPWM_CTL1_MD_LSB   0
`define TPWM_CTL1_EEE_BIT  5
`define TPWM_CTL1_EST_BIT  6
`define TPWM_IOC2_ETS_LSB  0
`define TPWM_IOC2_EES_LSB  2

`define TPWM_MODE_TRIG_PWM 3'h2
`define TPWM_CNT_IDLE      16'hffff
`define TPWM_CNT_ZERO      16'h0000
`define TPWM_CTL_RESET     8'h00
`define TPWM_CCR_RESET     16'h0000
`define TPWM_PRESC_W       8

`define TPWM_EDGE_NONE     2'h0
`define TPWM_EDGE_RISE     2'h1
`define TPWM_EDGE_FALL     2'h2
`define TPWM_EDGE_BOTH     2'h3

`endif

// File: hdl/tpwm_pkg.sv
/*
  types of the triggered pwm timer.
  assumes tpwm_consts.svh is available for the constants.
*/
package tpwm_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } run_state_t;

    typedef logic [15:0] count_t;

endpackage

// File: hdl/triggered_pwm_timer.sv
/*
  16-bit timer channel in externally triggered pwm mode,
  with register port, prescaler, trigger and event inputs,
  shadowed compares and compare event pulses.
  assumes trig_in and event_in are synchronous to clk_sys
  and a master that never issues read and write together.

*/
`timescale 1ns/1ps
`include "tpwm_consts.svh"

module triggered_pwm_timer #(
    parameter int DATA_W = `TPWM_DATA_W,
    parameter int ADDR_W = `TPWM_ADDR_W,
    parameter int PRE_W  = `TPWM_PRESC_W
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              trig_in,
    input  wire logic              event_in,
    output logic                   square_wave_output,
    output logic      [2:0]        pwm_channel_output,
    output logic                   period_compare_irq,
    output logic      [2:0]        channel_compare_irq
);

    // edge detect against a selected edge
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic       now,
                                      input logic       was);
        logic r;
        r = 1'b0;
        case (sel)
            `TPWM_EDGE_RISE: r = now & ~was;
            `TPWM_EDGE_FALL: r = ~now & was;
            `TPWM_EDGE_BOTH: r = now ^ was;
            default:         r = 1'b0;
        endcase
        return r;
    endfunction

    // registers
    logic [7:0]        ctl0_q;
    logic [7:0]        ctl1_q;
    logic [7:0]        ioc0_q;
    logic [7:0]        ioc2_q;
    logic [15:0]       ccr_q   [4];
    logic [15:0]       shadow_q[4];
    logic              arm_q;
    logic              sw_trig_q;
    logic [DATA_W-1:0] rdata_q;

    // core state
    tpwm_pkg::run_state_t state_q;
    tpwm_pkg::run_state_t state_d;
    tpwm_pkg::count_t     cnt_q;
    tpwm_pkg::count_t     cnt_d;
    logic [PRE_W-1:0]     presc_q;
    logic                 trig_prev_q;
    logic                 event_prev_q;
    logic                 sq_q;
    logic [2:0]           act_q;
    logic                 period_irq_q;
    logic [2:0]           chan_irq_q;
    logic [2:0]           chan_irq_pin_q;

    // decoded controls
    logic       wr_ctl0;
    logic       wr_ctl1;
    logic       wr_ccr1;
    logic       enable;
    logic       mode_ok;
    logic [2:0] cks;
    logic       ext_trig;
    logic       trigger;
    logic       presc_tick;
    logic       event_tick;
    logic       tick;
    logic       period_hit;
    logic       reload;
    logic       running;
    logic [15:0] eff_buf[4];

    assign wr_ctl0 = reg_wr && (reg_addr == `TPWM_OFS_CTL0);
    assign wr_ctl1 = reg_wr && (reg_addr == `TPWM_OFS_CTL1);
    assign wr_ccr1 = reg_wr && (reg_addr == `TPWM_OFS_CCR1);

    assign enable  = ctl0_q[`TPWM_CTL0_CE_BIT];
    assign cks     = ctl0_q[`TPWM_CTL0_CKS_LSB +: 3];
    assign mode_ok = (ctl1_q[`TPWM_CTL1_MD_LSB +: 3] == `TPWM_MODE_TRIG_PWM);

    // control 0: clock select and count enable
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctl0_q <= `TPWM_CTL_RESET;
        end else if (wr_ctl0) begin
            ctl0_q <= reg_wdata[7:0];
        end
    end

    // control 1: mode and event select; trigger bit not stored
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctl1_q <= `TPWM_CTL_RESET;
        end else if (wr_ctl1) begin
            ctl1_q <= reg_wdata[7:0] & ~(8'h01 << `TPWM_CTL1_EST_BIT);
        end
    end

    // software trigger pulse
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sw_trig_q <= 1'b0;
        end else begin
            sw_trig_q <= wr_ctl1 && reg_wdata[`TPWM_CTL1_EST_BIT];
        end
    end

    // output control and edge control
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ioc0_q <= `TPWM_CTL_RESET;
            ioc2_q <= `TPWM_CTL_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `TPWM_OFS_IOC0) begin
                ioc0_q <= reg_wdata[7:0];
            end
            if (reg_addr == `TPWM_OFS_IOC2) begin
                ioc2_q <= reg_wdata[7:0] & 8'h0f;
            end
        end
    end

    // compare registers
    generate
        for (genvar m = 0; m < 4; m++) begin : g_ccr
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    ccr_q[m] <= `TPWM_CCR_RESET;
                end else if (reg_wr && (reg_addr == `TPWM_OFS_CCR0 + ADDR_W'(m))) begin
                    ccr_q[m] <= reg_wdata[15:0];
                end
            end
        end
    endgenerate

    // reload arm: a write wins over the reload clearing it
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            arm_q <= 1'b0;
        end else if (wr_ccr1) begin
            arm_q <= 1'b1;
        end else if (reload) begin
            arm_q <= 1'b0;
        end
    end

    // prescaler for the internal count clock
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            presc_q <= '0;
        end else if (state_q != tpwm_pkg::ST_RUN) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    assign presc_tick = (cks == 3'h0) ? 1'b1 :
                        (presc_q[cks - 3'h1 +: 1] == 1'b1) &&
                        ((presc_q & ((PRE_W'(1) << cks) - 1'b1)) == ((PRE_W'(1) << cks) - 1'b1));

    // input edge history
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            trig_prev_q  <= 1'b0;
            event_prev_q <= 1'b0;
        end else begin
            trig_prev_q  <= trig_in;
            event_prev_q <= event_in;
        end
    end

    assign ext_trig   = edge_hit(ioc2_q[`TPWM_IOC2_ETS_LSB +: 2], trig_in, trig_prev_q);
    assign event_tick = edge_hit(ioc2_q[`TPWM_IOC2_EES_LSB +: 2], event_in, event_prev_q);
    assign trigger    = ext_trig || sw_trig_q;
    assign tick       = ctl1_q[`TPWM_CTL1_EEE_BIT] ? event_tick : presc_tick;

    assign running    = (state_q == tpwm_pkg::ST_RUN);
    assign period_hit = running && !trigger && tick && (cnt_q == shadow_q[0]);
    assign reload     = period_hit && arm_q;

    // compare values seen by the next count
    always_comb begin
        for (int m = 0; m < 4; m++) begin
            eff_buf[m] = reload ? ccr_q[m] : shadow_q[m];
        end
    end

    // run state
    always_comb begin
        state_d = state_q;
        case (state_q)
            tpwm_pkg::ST_IDLE: begin
                if (enable && mode_ok) begin
                    state_d = tpwm_pkg::ST_WAIT;
                end
            end
            tpwm_pkg::ST_WAIT: begin
                if (!enable || !mode_ok) begin
                    state_d = tpwm_pkg::ST_IDLE;
                end else if (trigger) begin
                    state_d = tpwm_pkg::ST_RUN;
                end
            end
            tpwm_pkg::ST_RUN: begin
                if (!enable || !mode_ok) begin
                    state_d = tpwm_pkg::ST_IDLE;
                end
            end
            default: state_d = tpwm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= tpwm_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // counter next value
    always_comb begin
        cnt_d = cnt_q;
        if (state_d != tpwm_pkg::ST_RUN) begin
            cnt_d = `TPWM_CNT_IDLE;
        end else if (trigger) begin
            cnt_d = `TPWM_CNT_ZERO;
        end else if (period_hit) begin
            cnt_d = `TPWM_CNT_ZERO;
        end else if (tick) begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_q <= `TPWM_CNT_IDLE;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // shadows: loaded at enable and at an armed period clear
    generate
        for (genvar m = 0; m < 4; m++) begin : g_shadow
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    shadow_q[m] <= `TPWM_CCR_RESET;
                end else if (state_q == tpwm_pkg::ST_IDLE && state_d == tpwm_pkg::ST_WAIT) begin
                    shadow_q[m] <= ccr_q[m];
                end else if (reload) begin
                    shadow_q[m] <= ccr_q[m];
                end
            end
        end
    endgenerate

    // period event and square wave
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            period_irq_q <= 1'b0;
            sq_q         <= 1'b0;
        end else begin
            period_irq_q <= period_hit;
            if (state_d != tpwm_pkg::ST_RUN) begin
                sq_q <= 1'b0;
            end else if (period_hit) begin
                sq_q <= ~sq_q;
            end
        end
    end

    // pwm channels 1 to 3
    generate
        for (genvar k = 0; k < 3; k++) begin : g_chan
            logic restart;
            logic match;
            assign restart = running ? (trigger || period_hit) : (state_d == tpwm_pkg::ST_RUN);
            // a duty above the period never equals the count
            assign match = (state_d == tpwm_pkg::ST_RUN) && (restart || tick) &&
                           (cnt_d == eff_buf[k+1]);

            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    act_q[k]      <= 1'b0;
                    chan_irq_q[k] <= 1'b0;
                end else begin
                    chan_irq_q[k] <= match;
                    if (state_d != tpwm_pkg::ST_RUN) begin
                        act_q[k] <= 1'b0;
                    end else if (match) begin
                        act_q[k] <= 1'b0;
                    end else if (restart) begin
                        act_q[k] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // pins and channel events: registered together so an event meets its pin edge
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            square_wave_output <= 1'b0;
            pwm_channel_output <= 3'h0;
            chan_irq_pin_q     <= 3'h0;
        end else begin
            chan_irq_pin_q     <= chan_irq_q;
            square_wave_output <= ioc0_q[0] ? sq_q : ioc0_q[1];
            for (int k = 0; k < 3; k++) begin
                pwm_channel_output[k] <= (ioc0_q[2*k+2] & act_q[k]) ^ ioc0_q[2*k+3];
            end
        end
    end

    assign period_compare_irq  = period_irq_q;
    assign channel_compare_irq = chan_irq_pin_q;

    // read data, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `TPWM_OFS_CTL0: rdata_q <= {8'h00, ctl0_q};
                `TPWM_OFS_CTL1: rdata_q <= {8'h00, ctl1_q};
                `TPWM_OFS_IOC0: rdata_q <= {8'h00, ioc0_q};
                `TPWM_OFS_IOC2: rdata_q <= {8'h00, ioc2_q};
                `TPWM_OFS_CNT:  rdata_q <= cnt_q;
                `TPWM_OFS_CCR0: rdata_q <= ccr_q[0];
                `TPWM_OFS_CCR1: rdata_q <= ccr_q[1];
                `TPWM_OFS_CCR2: rdata_q <= ccr_q[2];
                `TPWM_OFS_CCR3: rdata_q <= ccr_q[3];
                default:        rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

endmodule // triggered_pwm_timer

// File: sim/trigger_source.sv
/* model of the trigger and event sources at the timer pins.
   assumes the bench commands levels; lines change just after an edge. */
`timescale 1ns/1ps
module trigger_source (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic trig_req,
    input  wire logic ev_req,
    output logic      trig_in,
    output logic      event_in
);
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            trig_in  <= 1'b0;
            event_in <= 1'b0;
        end else begin
            trig_in  <= trig_req;
            event_in <= ev_req;
        end
    end
endmodule // trigger_source

// File: sim/triggered_pwm_timer_bench.sv
/* self-checking bench for triggered_pwm_timer.
   assumes the consts header on the include path and trigger_source. */
`timescale 1ns/1ps
`include "tpwm_consts.svh"
module triggered_pwm_timer_bench;
    logic        clk_sys   = 1'b0;
    logic        resetn    = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        trig_req  = 1'b0;
    logic        ev_req    = 1'b0;
    logic [15:0] reg_rdata;
    logic        trig_in;
    logic        event_in;
    logic        square_wave_output;
    logic [2:0]  pwm_channel_output;
    logic        period_compare_irq;
    logic [2:0]  channel_compare_irq;
    int          fail_count = 0;
    int          n_compared = 0;
    int          pc;
    int          sq_t;
    int          ci[3];
    int          hi[3];

    always #10 clk_sys = ~clk_sys;

    triggered_pwm_timer i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
        .event_in(event_in), .square_wave_output(square_wave_output),
        .pwm_channel_output(pwm_channel_output), .period_compare_irq(period_compare_irq),
        .channel_compare_irq(channel_compare_irq));

    trigger_source i_src (
        .clk_sys(clk_sys), .resetn(resetn), .trig_req(trig_req), .ev_req(ev_req),
        .trig_in(trig_in), .event_in(event_in));

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkr(input string what, input int lo, input int hi_b, input logic [15:0] got);
        n_compared++;
        if (((got >= lo) && (got <= hi_b)) !== 1'b1) begin
            fail_count++;
            $display("wrong value %s expected %0d..%0d seen %h", what, lo, hi_b, got);
        end
    endtask

    // counts events, square wave toggles and high output cycles over n cycles
    task automatic measure(input int n);
        logic s;
        pc   = 0;
        sq_t = 0;
        for (int k = 0; k < 3; k++) begin
            ci[k] = 0;
            hi[k] = 0;
        end
        s = square_wave_output;
        repeat (n) begin
            @(negedge clk_sys);
            if (period_compare_irq === 1'b1) pc++;
            if (square_wave_output !== s) sq_t++;
            s = square_wave_output;
            for (int k = 0; k < 3; k++) begin
                if (channel_compare_irq[k] === 1'b1) ci[k]++;
                if (pwm_channel_output[k] === 1'b1) hi[k]++;
            end
        end
    endtask

    task automatic t_regs;
        logic [15:0] d;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], d);
            chk("reset read", (a == 4) ? 16'hffff : 16'h0000, d);
        end
        wr(`TPWM_OFS_IOC2, 16'h00ff);
        rd(`TPWM_OFS_IOC2, d);
        chk("edge control", 16'h000f, d);
        wr(`TPWM_OFS_CTL1, 16'h0042);
        rd(`TPWM_OFS_CTL1, d);
        chk("control one", 16'h0002, d);
        wr(4'hf, 16'h1234);
        rd(4'hf, d);
        chk("unmapped", 16'h0000, d);
    endtask

    task automatic t_pwm;
        logic [15:0] d;
        wr(`TPWM_OFS_CCR0, 16'h0003);
        wr(`TPWM_OFS_CCR2, 16'h0002);
        wr(`TPWM_OFS_CCR3, 16'h0005);
        wr(`TPWM_OFS_CCR1, 16'h0001);
        wr(`TPWM_OFS_IOC0, 16'h0075);
        wr(`TPWM_OFS_IOC2, 16'h0005);
        wr(`TPWM_OFS_CTL1, 16'h0002);
        wr(`TPWM_OFS_CTL0, 16'h0080);
        repeat (10) @(posedge clk_sys);
        rd(`TPWM_OFS_CNT, d);
        chk("waiting counter", 16'hffff, d);
        wr(`TPWM_OFS_CTL1, 16'h0042);
        rd(`TPWM_OFS_CNT, d);
        chkr("started counter", 0, 3, d);
        repeat (6) @(negedge clk_sys);
        measure(40);
        chk("period events", 16'd10, 16'(pc));
        chk("ch1 events", 16'd10, 16'(ci[0]));
        chk("ch1 active", 16'd10, 16'(hi[0]));
        chk("ch2 events", 16'd10, 16'(ci[1]));
        chk("ch2 low", 16'd20, 16'(40 - hi[1]));
        chk("ch3 events", 16'd0, 16'(ci[2]));
        chk("ch3 level", 16'd40, 16'(hi[2]));
        chk("square toggles", 16'd10, 16'(sq_t));
    endtask

    task automatic t_shadow;
        wr(`TPWM_OFS_CCR2, 16'h0001);
        repeat (8) @(negedge clk_sys);
        measure(40);
        chk("ch2 low unarmed", 16'd20, 16'(40 - hi[1]));
        wr(`TPWM_OFS_CCR1, 16'h0001);
        repeat (8) @(negedge clk_sys);
        measure(40);
        chk("ch2 low armed", 16'd10, 16'(40 - hi[1]));
        wr(`TPWM_OFS_CCR3, 16'h0000);
        wr(`TPWM_OFS_CCR1, 16'h0001);
        repeat (8) @(negedge clk_sys);
        measure(40);
        chk("ch3 zero duty high", 16'd0, 16'(hi[2]));
        chk("ch3 zero duty events", 16'd10, 16'(ci[2]));
    endtask

    task automatic t_ext;
        logic [15:0] d;
        wr(`TPWM_OFS_CCR0, 16'h00ff);
        wr(`TPWM_OFS_CCR1, 16'h0001);
        repeat (100) @(posedge clk_sys);
        trig_req <= 1'b1;
        repeat (20) @(posedge clk_sys);
        rd(`TPWM_OFS_CNT, d);
        chkr("after rise", 15, 30, d);
        trig_req <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rd(`TPWM_OFS_CNT, d);
        chkr("after fall", 35, 60, d);
        trig_req <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(`TPWM_OFS_CNT, d);
        chkr("after retrigger", 0, 8, d);
    endtask

    task automatic t_event;
        logic [15:0] d;
        wr(`TPWM_OFS_CTL0, 16'h0000);
        rd(`TPWM_OFS_CNT, d);
        chk("stopped counter", 16'hffff, d);
        measure(20);
        chk("stopped events", 16'd0, 16'(pc + ci[0]));
        wr(`TPWM_OFS_CTL1, 16'h0021);
        wr(`TPWM_OFS_CTL0, 16'h0080);
        wr(`TPWM_OFS_CTL1, 16'h0061);
        rd(`TPWM_OFS_CNT, d);
        chk("other mode counter", 16'hffff, d);
        wr(`TPWM_OFS_CTL1, 16'h0022);
        wr(`TPWM_OFS_CTL1, 16'h0062);
        repeat (20) @(posedge clk_sys);
        rd(`TPWM_OFS_CNT, d);
        chk("no events", 16'h0000, d);
        repeat (5) begin
            @(posedge clk_sys);
            ev_req <= 1'b1;
            repeat (3) @(posedge clk_sys);
            ev_req <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        rd(`TPWM_OFS_CNT, d);
        chk("event count", 16'h0005, d);
        wr(`TPWM_OFS_CTL1, 16'h0002);
        wr(`TPWM_OFS_CTL0, 16'h0082);
        wr(`TPWM_OFS_CTL1, 16'h0042);
        repeat (40) @(posedge clk_sys);
        rd(`TPWM_OFS_CNT, d);
        chkr("prescaled count", 9, 11, d);
    endtask

    initial begin
        #(20 * 20000);
        fail_count++;
        results();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        t_regs();
        t_pwm();
        t_shadow();
        t_ext();
        t_event();
        results();
    end
endmodule // triggered_pwm_timer_bench

// File: sim/triggered_pwm_timer_checker.sv
/* port checker for triggered_pwm_timer.
   assumes one-cycle strobes and the register map of the consts header. */
`timescale 1ns/1ps
module triggered_pwm_timer_checker #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 4
) (
    input wire logic              clk_sys,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              trig_in,
    input wire logic              event_in,
    input wire logic              square_wave_output,
    input wire logic [2:0]        pwm_channel_output,
    input wire logic              period_compare_irq,
    input wire logic [2:0]        channel_compare_irq
);
    logic [7:0]        pins_q;
    logic              ce_q;
    logic [DATA_W-1:0] per_q;
    logic [3:0]        wr_q;
    wire               quiet = (wr_q == 4'h0) && !reg_wr;

    // snooped register copies
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pins_q <= 8'h00;
            ce_q   <= 1'b0;
            per_q  <= '0;
            wr_q   <= 4'h0;
        end else begin
            wr_q <= {wr_q[2:0], reg_wr};
            if (reg_wr && reg_addr == 4'h2) pins_q <= reg_wdata[7:0];
            if (reg_wr && reg_addr == 4'h0) ce_q <= reg_wdata[7];
            if (reg_wr && reg_addr == 4'h5) per_q <= reg_wdata;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside a read");
    chk_swtrig_reads_zero: assert property ($past(reg_rd) && $past(reg_addr) == 4'h1 |-> !reg_rdata[6])
        else $error("software trigger bit read back set");
    chk_edge_reg_width: assert property ($past(reg_rd) && $past(reg_addr) == 4'h3 |-> reg_rdata[15:4] == 12'h000)
        else $error("edge control upper bits not zero");
    chk_period_readback: assert property ($past(reg_rd) && $past(reg_addr) == 4'h5 |-> reg_rdata == per_q)
        else $error("period compare readback differs");
    chk_ch1_fall_irq: assert property (quiet && pins_q[2] && !pins_q[3] &&
        $fell(pwm_channel_output[0]) |-> channel_compare_irq[0])
        else $error("channel 1 fell without its compare event");
    chk_irq_output_idle: assert property (quiet && pins_q[4] && channel_compare_irq[1] |->
        pwm_channel_output[1] == pins_q[5])
        else $error("channel 2 not inactive at its compare event");
    chk_stop_no_irq: assert property ((!ce_q) [*4] |-> !period_compare_irq && channel_compare_irq == 3'h0)
        else $error("compare event while stopped");
    chk_period_irq_pulse: assert property (period_compare_irq |=> !period_compare_irq)
        else $error("period event longer than one cycle");

    cover property (period_compare_irq);
    cover property (channel_compare_irq[1]);
    cover property (quiet && $fell(pwm_channel_output[0]));
endmodule // triggered_pwm_timer_checker

bind triggered_pwm_timer triggered_pwm_timer_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_chk (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
    .event_in(event_in), .square_wave_output(square_wave_output),
    .pwm_channel_output(pwm_channel_output), .period_compare_irq(period_compare_irq),
    .channel_compare_irq(channel_compare_irq));
